// ---- logic/gfm_params.svh ----
// Register indices, field positions and reset values of the gain-flag pin multiplexer
`ifndef GFM_PARAMS_SVH
`define GFM_PARAMS_SVH

// Register indices; byte address is four times the index
`define GFM_IDX_FIRST_SRC    10'h19b
`define GFM_IDX_SECOND_SRC   10'h19c
`define GFM_IDX_FLAG_EN      10'h19e
`define GFM_IDX_OVR_SEL      10'h1b0
`define GFM_IDX_OVR_DIR      10'h1b1
`define GFM_IDX_OVR_VAL      10'h1b2
`define GFM_IDX_PIN_STATUS   10'h1bf

// Fields of gain_flag_output_enable
`define GFM_BIT_FIRST_EN     0
`define GFM_BIT_SECOND_EN    1
`define GFM_BIT_MERGE        4

// Pin positions of the two flag pins
`define GFM_PIN_FIRST_FLAG   2
`define GFM_PIN_SECOND_FLAG  3

`define GFM_REG_RESET        8'h00
`define GFM_SEL_WIDTH        3

`endif

// ---- logic/gfm_pkg.sv ----
// Types shared by the gain-flag pin multiplexer
`default_nettype none
package gfm_pkg;
    typedef enum logic [2:0] {
        GFM_SRC_ADC_RESET = 3'b000,
        GFM_SRC_PEAK_THR0 = 3'b100,
        GFM_SRC_PEAK_THR1 = 3'b101,
        GFM_SRC_PEAK_LOW  = 3'b110
    } gfm_flag_src_t;
endpackage : gfm_pkg
`default_nettype wire

// ---- logic/gfm_flag_select.sv ----
// One flag-pin source selector with reset-pulse merge and enable
`timescale 1ns/100ps
`default_nettype none
module gfm_flag_select (
    input  wire logic [2:0] source,
    input  wire logic       enable,
    input  wire logic       merge,
    input  wire logic       adc_reset_pulse,
    input  wire logic       peak_above_thr0,
    input  wire logic       peak_above_thr1,
    input  wire logic       peak_below_low,
    output logic            flag
);
    import gfm_pkg::*;

    logic peak;
    logic chosen;

    always_comb begin
        peak   = 1'b0;
        chosen = 1'b0;
        case (gfm_flag_src_t'(source))
            GFM_SRC_ADC_RESET: chosen = adc_reset_pulse;
            GFM_SRC_PEAK_THR0: peak = peak_above_thr0;
            GFM_SRC_PEAK_THR1: peak = peak_above_thr1;
            GFM_SRC_PEAK_LOW:  peak = peak_below_low;
            default:           peak = 1'b0;
        endcase
        // Unlisted codes give a quiet flag, even with merge on
        if (gfm_flag_src_t'(source) != GFM_SRC_ADC_RESET) begin
            chosen = peak | (merge & adc_reset_pulse & (source[2] & ~(source[1] & source[0])));
        end
        flag = enable & chosen;
    end
endmodule : gfm_flag_select
`default_nettype wire

// ---- logic/gfm_pin_mux.sv ----
// Gain port pin multiplexer: flag pins, per-pin GPIO override, APB registers
//
// Contract
// - Merge bit set: ADC reset pulse ORed into the selected peak flag.
// - Second flag enable 0 holds pin 4 low; 1 drives second selected flag.
// - First flag enable 0 holds pin 3 low; 1 drives first selected flag.
// - Override select bit n makes pin n+1 GPIO, above every other function.
// - Overridden pin: direction bit 1 means output, 0 means input.
// - Overridden output pin drives its output value bit.
// - Enable, override select, direction and value registers reset to zero.
// - First selector: 000 reset pulse, 100 thr0, 101 thr1, 110 below low.
// - Second selector uses the same four encodings for pin 4.
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "gfm_params.svh"
module gfm_pin_mux (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        adc_reset_pulse,
    input  wire logic        peak_above_thr0,
    input  wire logic        peak_above_thr1,
    input  wire logic        peak_below_low,
    input  wire logic [3:0]  gain_port_pin_in,
    output logic      [3:0]  gain_port_pin_out,
    output logic      [3:0]  gain_port_pin_oe
);
    import gfm_pkg::*;

    logic [7:0]  gain_flag_output_enable;
    logic [7:0]  first_flag_source;
    logic [7:0]  second_flag_source;
    logic [7:0]  pin_override_select;
    logic [7:0]  pin_override_direction;
    logic [7:0]  override_value_bits;
    logic [7:0]  next_enable;
    logic [7:0]  next_first_src;
    logic [7:0]  next_second_src;
    logic [7:0]  next_ovr_sel;
    logic [7:0]  next_ovr_dir;
    logic [7:0]  next_ovr_val;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [3:0]  next_pin_out;
    logic [3:0]  next_pin_oe;
    logic        first_flag;
    logic        second_flag;
    logic        access;
    logic        commit;
    logic        mapped;
    logic [9:0]  index;
    logic [31:0] read_word;

    gfm_flag_select u_first_flag (
        .source          (first_flag_source[`GFM_SEL_WIDTH-1:0]),
        .enable          (gain_flag_output_enable[`GFM_BIT_FIRST_EN]),
        .merge           (gain_flag_output_enable[`GFM_BIT_MERGE]),
        .adc_reset_pulse (adc_reset_pulse),
        .peak_above_thr0 (peak_above_thr0),
        .peak_above_thr1 (peak_above_thr1),
        .peak_below_low  (peak_below_low),
        .flag            (first_flag)
    );

    gfm_flag_select u_second_flag (
        .source          (second_flag_source[`GFM_SEL_WIDTH-1:0]),
        .enable          (gain_flag_output_enable[`GFM_BIT_SECOND_EN]),
        .merge           (gain_flag_output_enable[`GFM_BIT_MERGE]),
        .adc_reset_pulse (adc_reset_pulse),
        .peak_above_thr0 (peak_above_thr0),
        .peak_above_thr1 (peak_above_thr1),
        .peak_below_low  (peak_below_low),
        .flag            (second_flag)
    );

    // APB slave: one wait state, so pready is a registered answer
    always_comb begin
        index     = paddr[11:2];
        access    = psel & penable;
        commit    = access & pready;
        mapped    = 1'b1;
        read_word = 32'h0000_0000;
        case (index)
            `GFM_IDX_FIRST_SRC:  read_word = {24'h00_0000, first_flag_source};
            `GFM_IDX_SECOND_SRC: read_word = {24'h00_0000, second_flag_source};
            `GFM_IDX_FLAG_EN:    read_word = {24'h00_0000, gain_flag_output_enable};
            `GFM_IDX_OVR_SEL:    read_word = {24'h00_0000, pin_override_select};
            `GFM_IDX_OVR_DIR:    read_word = {24'h00_0000, pin_override_direction};
            `GFM_IDX_OVR_VAL:    read_word = {24'h00_0000, override_value_bits};
            `GFM_IDX_PIN_STATUS: read_word = {20'h0_0000, gain_port_pin_in, gain_port_pin_oe, gain_port_pin_out};
            default:             mapped = 1'b0;
        endcase
        next_pready  = access & ~pready;
        next_prdata  = (access & ~pready & ~pwrite) ? read_word : prdata;
        next_pslverr = access & ~pready & ~mapped;
        next_enable     = gain_flag_output_enable;
        next_first_src  = first_flag_source;
        next_second_src = second_flag_source;
        next_ovr_sel    = pin_override_select;
        next_ovr_dir    = pin_override_direction;
        next_ovr_val    = override_value_bits;
        // Writes land only at the edge that completes the transfer
        if (commit & pwrite & ~pslverr) begin
            case (index)
                `GFM_IDX_FIRST_SRC:  next_first_src  = pwdata[7:0];
                `GFM_IDX_SECOND_SRC: next_second_src = pwdata[7:0];
                `GFM_IDX_FLAG_EN:    next_enable     = pwdata[7:0];
                `GFM_IDX_OVR_SEL:    next_ovr_sel    = pwdata[7:0];
                `GFM_IDX_OVR_DIR:    next_ovr_dir    = pwdata[7:0];
                `GFM_IDX_OVR_VAL:    next_ovr_val    = pwdata[7:0];
                default:             next_enable     = gain_flag_output_enable;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gain_flag_output_enable <= `GFM_REG_RESET;
            first_flag_source       <= `GFM_REG_RESET;
            second_flag_source      <= `GFM_REG_RESET;
            pin_override_select     <= `GFM_REG_RESET;
            pin_override_direction  <= `GFM_REG_RESET;
            override_value_bits     <= `GFM_REG_RESET;
            prdata                  <= 32'h0000_0000;
            pready                  <= 1'b0;
            pslverr                 <= 1'b0;
        end else begin
            gain_flag_output_enable <= next_enable;
            first_flag_source       <= next_first_src;
            second_flag_source      <= next_second_src;
            pin_override_select     <= next_ovr_sel;
            pin_override_direction  <= next_ovr_dir;
            override_value_bits     <= next_ovr_val;
            prdata                  <= next_prdata;
            pready                  <= next_pready;
            pslverr                 <= next_pslverr;
        end
    end

    // Pin drivers; pins 1 and 2 carry no flag, so they idle low when not overridden
    always_comb begin
        next_pin_out = 4'h0;
        next_pin_oe  = 4'hf;
        next_pin_out[`GFM_PIN_FIRST_FLAG]  = first_flag;
        next_pin_out[`GFM_PIN_SECOND_FLAG] = second_flag;
        for (int n = 0; n < 4; n++) begin
            if (pin_override_select[n]) begin
                next_pin_oe[n]  = pin_override_direction[n];
                next_pin_out[n] = pin_override_direction[n] & override_value_bits[n];
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gain_port_pin_out <= 4'h0;
            gain_port_pin_oe  <= 4'hf;
        end else begin
            gain_port_pin_out <= next_pin_out;
            gain_port_pin_oe  <= next_pin_oe;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_merge_or_first: assert property ($past(gain_flag_output_enable[4] && gain_flag_output_enable[0]
        && !pin_override_select[2] && first_flag_source[2:0] == 3'b100 && adc_reset_pulse)
        |-> gain_port_pin_out[2]) else $error("merged reset pulse missing on pin 3");
    a_second_forced_low: assert property (!gain_flag_output_enable[1] && !pin_override_select[3]
        |=> !gain_port_pin_out[3] && gain_port_pin_oe[3]) else $error("pin 4 not held low");
    a_first_forced_low: assert property (!gain_flag_output_enable[0] && !pin_override_select[2]
        |=> !gain_port_pin_out[2] && gain_port_pin_oe[2]) else $error("pin 3 not held low");
    a_override_wins: assert property (pin_override_select[3] && pin_override_direction[3]
        && gain_flag_output_enable[1] |=> gain_port_pin_out[3] == $past(override_value_bits[3]))
        else $error("override did not win on pin 4");
    a_gpio_direction: assert property (pin_override_select[0]
        |=> gain_port_pin_oe[0] == $past(pin_override_direction[0])) else $error("pin 1 direction wrong");
    a_gpio_value: assert property (pin_override_select[2] && pin_override_direction[2]
        |=> gain_port_pin_out[2] == $past(override_value_bits[2])) else $error("pin 3 value wrong");
    a_reset_zero: assert property (@(posedge mclk) !$past(rstn) |-> gain_flag_output_enable == 8'h00
        && pin_override_select == 8'h00 && pin_override_direction == 8'h00 && override_value_bits == 8'h00)
        else $error("registers not zero after reset");
    a_first_below_low: assert property (gain_flag_output_enable[0] && !gain_flag_output_enable[4]
        && !pin_override_select[2] && first_flag_source[2:0] == 3'b110
        |=> gain_port_pin_out[2] == $past(peak_below_low)) else $error("pin 3 low-threshold flag wrong");
    a_second_thr1: assert property (gain_flag_output_enable[1] && !pin_override_select[3]
        && second_flag_source[2:0] == 3'b101 |=> gain_port_pin_out[3]
        == $past(peak_above_thr1 | (gain_flag_output_enable[4] & adc_reset_pulse)))
        else $error("pin 4 threshold 1 flag wrong");
    a_input_undriven: assert property (pin_override_select[1] && !pin_override_direction[1]
        |=> !gain_port_pin_oe[1] && !gain_port_pin_out[1]) else $error("input pin 2 driven");
    a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("APB answer late");
    // Error is only meaningful beside ready; a stray one would confuse the master
    a_error_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_unmapped_refused: assert property (psel && penable && !pready && !mapped |=> pready && pslverr)
        else $error("unmapped access not refused");
    a_write_lands: assert property (psel && penable && pready && pwrite && !pslverr && index == `GFM_IDX_OVR_SEL
        |=> pin_override_select == $past(pwdata[7:0])) else $error("override select write lost");
    a_first_thr0: assert property (gain_flag_output_enable[0] && !gain_flag_output_enable[4]
        && !pin_override_select[2] && first_flag_source[2:0] == 3'b100
        |=> gain_port_pin_out[2] == $past(peak_above_thr0)) else $error("pin 3 threshold 0 flag wrong");
    a_second_reset_code: assert property (gain_flag_output_enable[1] && !pin_override_select[3]
        && second_flag_source[2:0] == 3'b000
        |=> gain_port_pin_out[3] == $past(adc_reset_pulse)) else $error("pin 4 reset pulse flag wrong");

    c_merge_pulse: cover property (gain_flag_output_enable[4] && adc_reset_pulse ##1 gain_port_pin_out[2]);
    c_gpio_output: cover property (pin_override_select[3] && pin_override_direction[3] ##1 gain_port_pin_out[3]);
    c_gpio_input: cover property (pin_override_select[0] && !pin_override_direction[0]);
    c_apb_error: cover property (pready && pslverr);
endmodule : gfm_pin_mux
`default_nettype wire

// ---- testbench/gfm_far_model.sv ----
// Far-side model: gain logic raising flags and a host driving the pins
`timescale 1ns/100ps
`default_nettype none
module gfm_far_model (
    input  wire logic [3:0] flag_req,
    input  wire logic [3:0] host_val,
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    output logic      [3:0] flag_src,
    output logic      [3:0] pin_level
);
    // Flags follow the command at once, no smoothing
    assign flag_src = flag_req;
    // Host drives only where the device has let go, so no contention
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & host_val);
endmodule : gfm_far_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the gain-flag pin multiplexer
`timescale 1ns/100ps
`default_nettype none
`include "gfm_params.svh"
module tb_top;
    import gfm_pkg::*;
    logic        mclk       = 1'b0;
    logic        rstn       = 1'b0;
    logic [11:0] paddr      = 12'h000;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [31:0] pwdata     = 32'h0;
    logic [3:0]  flags      = 4'h0;
    logic [3:0]  host_val   = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  src;
    logic [3:0]  pin_in;
    logic [3:0]  pin_out;
    logic [3:0]  pin_oe;
    logic [31:0] rd;
    logic [31:0] w;
    logic        err;
    logic [7:0]  exp_p;
    logic [7:0]  sh [6];
    logic [9:0]  ix [6]     = '{`GFM_IDX_FIRST_SRC, `GFM_IDX_SECOND_SRC, `GFM_IDX_FLAG_EN,
                                `GFM_IDX_OVR_SEL, `GFM_IDX_OVR_DIR, `GFM_IDX_OVR_VAL};
    logic [2:0]  codes [4]  = '{GFM_SRC_ADC_RESET, GFM_SRC_PEAK_THR0, GFM_SRC_PEAK_THR1, GFM_SRC_PEAK_LOW};
    integer      num_errors = 0;
    integer      n_tests    = 0;
    integer      seed       = 70682;

    always #10 mclk = ~mclk;

    gfm_far_model partner (.flag_req(flags), .host_val(host_val), .pin_out(pin_out), .pin_oe(pin_oe),
                           .flag_src(src), .pin_level(pin_in));
    gfm_pin_mux dut (.mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
                     .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                     .adc_reset_pulse(src[0]), .peak_above_thr0(src[1]), .peak_above_thr1(src[2]),
                     .peak_below_low(src[3]), .gain_port_pin_in(pin_in), .gain_port_pin_out(pin_out),
                     .gain_port_pin_oe(pin_oe));

    function automatic logic pick(input logic [2:0] s, input logic m, input logic [3:0] f);
        case (s)
            3'h0:    return f[0];
            3'h4:    return f[1] | (m & f[0]);
            3'h5:    return f[2] | (m & f[0]);
            3'h6:    return f[3] | (m & f[0]);
            default: return 1'b0;
        endcase
    endfunction : pick

    // Returns {oe, out} for the four pins
    function automatic logic [7:0] model_pins(input logic [3:0] f);
        logic [3:0] o;
        logic [3:0] e;
        o = 4'h0;
        e = 4'hf;
        o[2] = sh[2][0] & pick(sh[0][2:0], sh[2][4], f);
        o[3] = sh[2][1] & pick(sh[1][2:0], sh[2][4], f);
        for (int i = 0; i < 4; i++) begin
            if (sh[3][i]) begin
                e[i] = sh[4][i];
                o[i] = sh[4][i] & sh[5][i];
            end
        end
        return {e, o};
    endfunction : model_pins

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
        integer n;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            chk("pready", 32'h0, 32'h1);
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk_pins();
        // Wait for the pin flop; model only after it, so freshly driven flags are seen
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        exp_p = model_pins(flags);
        chk("pin_out", pin_out, exp_p[3:0]);
        chk("pin_oe", pin_oe, exp_p[7:4]);
        apb(1'b0, `GFM_IDX_PIN_STATUS, 32'h0);
        chk("status", rd, {20'h0, (exp_p[7:4] & exp_p[3:0]) | (~exp_p[7:4] & host_val), exp_p});
    endtask : chk_pins

    task automatic do_reset();
        rstn <= 1'b0;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) sh[i] = 8'h00;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ix[i], 32'h0);
            chk("reg reset", rd, 32'h0);
        end
        chk_pins();
    endtask : do_reset

    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    initial begin
        do_reset();
        apb(1'b1, 10'h001, 32'hff);
        chk("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b0, 10'h001, 32'h0);
        chk("unmapped data", rd, 32'h0);
        for (int k = 0; k < 80; k++) begin
            for (int i = 0; i < 6; i++) begin
                w = $random(seed);
                // Half the rounds use a legal selector code
                if (i < 2 && k[0]) w[2:0] = codes[k[2:1]];
                sh[i] = w[7:0];
                apb(1'b1, ix[i], w);
            end
            for (int i = 0; i < 6; i++) begin
                apb(1'b0, ix[i], 32'h0);
                chk("reg readback", rd, {24'h0, sh[i]});
                chk("mapped no error", {31'h0, err}, 32'h0);
            end
            w = $random(seed);
            flags    <= w[3:0];
            host_val <= w[7:4];
            chk_pins();
        end
        // Second reset with registers loaded
        do_reset();
        test_done();
    end

    initial begin
        // About four times the expected run of some 5000 cycles
        #400000;
        num_errors++;
        test_done();
    end
endmodule : tb_top
`default_nettype wire
